// ### hdl/amp_ctrl_pkg.sv
// constants, register map and state encoding of the amplifier shutdown and fault control
package amp_ctrl_pkg;

  // ************************************************
  // timing
  // ************************************************
  localparam longint CLK_PERIOD_NS    = 64'h0000_0000_0000_0004;
  localparam longint FADE_FRAMES      = 64'h0000_0000_0000_0080;
  localparam longint FRAME_RATE_HZ    = 64'h0000_0000_0001_7700;
  localparam longint NS_PER_S         = 64'h0000_0000_3B9A_CA00;
  localparam longint GAIN_STEPS       = 64'h0000_0000_0000_0100;
  localparam int     FADE_STEP_CYCLES = int'((FADE_FRAMES * NS_PER_S / FRAME_RATE_HZ) / (GAIN_STEPS * CLK_PERIOD_NS));
  localparam longint BCLK_LOSS_NS     = 64'h0000_0000_0000_01F4;
  localparam int     BCLK_LOSS_CYCLES = int'((BCLK_LOSS_NS + CLK_PERIOD_NS - 64'h1) / CLK_PERIOD_NS);
  localparam longint STRAP_NS         = 64'h0000_0000_0000_03E8;
  localparam int     STRAP_CYCLES     = int'((STRAP_NS + CLK_PERIOD_NS - 64'h1) / CLK_PERIOD_NS);

  // ************************************************
  // register map (index, byte address is index times four)
  // ************************************************
  localparam logic [5:0] REG_CLK_CFG_IDX  = 6'h01;
  localparam logic [5:0] REG_CTRL_IDX     = 6'h02;
  localparam logic [5:0] REG_VOLUME_IDX   = 6'h03;
  localparam logic [5:0] REG_FADE_CFG_IDX = 6'h16;
  localparam logic [5:0] REG_STATUS_IDX   = 6'h20;
  localparam logic [7:0] CLK_CFG_RST      = 8'h91;
  localparam logic [7:0] CTRL_RST         = 8'h00;
  localparam logic [7:0] VOLUME_RST       = 8'hC0;
  localparam logic [7:0] FADE_CFG_RST     = 8'h00;
  localparam int         CTRL_MUTE_BIT    = 3;
  localparam int         FADE_RATE_LSB    = 2;
  localparam int         FADE_RATE_MSB    = 3;
  localparam int         PLL_RATIO_LSB    = 0;
  localparam int         PLL_RATIO_MSB    = 3;
  localparam int         DTC_SHIFT        = 1;
  localparam int         STAT_STATE_LSB   = 0;
  localparam int         STAT_GAIN_LSB    = 8;
  localparam int         STAT_LIMIT_BIT   = 16;
  localparam int         STAT_BCLK_BIT    = 17;
  localparam int         STAT_STRAP_BIT   = 18;

  // ************************************************
  // bus addresses and states
  // ************************************************
  localparam logic [6:0] BUS_ADDR_LOW  = 7'h30;
  localparam logic [6:0] BUS_ADDR_HIGH = 7'h34;

  typedef enum logic [7:0] {
    ST_STRAP    = 8'h01,
    ST_RUN      = 8'h02,
    ST_FADE_OUT = 8'h04,
    ST_DOWN     = 8'h08,
    ST_FADE_IN  = 8'h10,
    ST_ERROR    = 8'h20,
    ST_UVLO     = 8'h40,
    ST_CLKLOSS  = 8'h80
  } amp_state_t;

endpackage : amp_ctrl_pkg

// ### hdl/amp_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module amp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : amp_sync

// ### hdl/amp_fade_ramp.sv
// linear gain ramp that moves one step toward its target per enable pulse
`timescale 1ns/1ps
module amp_fade_ramp (
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       step_en_in,
  input  wire logic       force_zero_in,
  input  wire logic [7:0] target_in,
  output logic      [7:0] gain_out,
  output logic            at_target_out
);
  logic [7:0] gain_q;
  logic [7:0] gain_d;

  // ************************************************
  // step toward target
  // ************************************************
  always_comb begin
    gain_d = gain_q;
    if (force_zero_in) begin
      gain_d = 8'h00;
    end else if (step_en_in && (gain_q < target_in)) begin
      gain_d = gain_q + 8'h01;
    end else if (step_en_in && (gain_q > target_in)) begin
      gain_d = gain_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gain_q <= 8'h00;
    end else begin
      gain_q <= gain_d;
    end
  end

  assign gain_out      = gain_q;
  assign at_target_out = (gain_q == target_in);
endmodule : amp_fade_ramp

// ### hdl/amp_shutdown_fault_control.sv
// shutdown, fade, protection and clock-loss sequencer with its register slave
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module amp_shutdown_fault_control (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        shutdown_request_pin_b_in,
  input  wire logic        bclk_in,
  input  wire logic        fault_pin_in,
  output logic             fault_pin_out,
  output logic             fault_pin_oe_b_out,
  input  wire logic        thermal_attack_in,
  input  wire logic        thermal_release_in,
  input  wire logic        over_temp_160_in,
  input  wire logic        temp_below_125_in,
  input  wire logic        short_circuit_in,
  input  wire logic        core_supply_low_in,
  input  wire logic        core_supply_ok_in,
  input  wire logic        clock_error_in,
  output logic [7:0]       gain_out,
  output logic             power_stage_en_out,
  output logic             digital_clk_en_out,
  output logic             analog_bias_en_out,
  output logic             pll_ref_osc_sel_out,
  output logic [3:0]       pll_ratio_out,
  output logic             output_weak_low_out,
  output logic             pop_suppress_out,
  output logic [6:0]       bus_address_out
);

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [10:0] sync_q;
  logic        sd_low;
  logic        bclk_s;
  logic        strap_s;
  logic        attack_s;
  logic        release_s;
  logic        hot_s;
  logic        cool_s;
  logic        short_s;
  logic        uv_low_s;
  logic        uv_ok_s;
  logic        clk_err_s;
  logic        sd_high_s;

  amp_sync #(
    .WIDTH (11)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        ({shutdown_request_pin_b_in, bclk_in, fault_pin_in, thermal_attack_in,
                   thermal_release_in, over_temp_160_in, temp_below_125_in, short_circuit_in,
                   core_supply_low_in, core_supply_ok_in, clock_error_in}),
    .q_out       (sync_q)
  );

  assign {sd_high_s, bclk_s, strap_s, attack_s, release_s, hot_s, cool_s, short_s,
          uv_low_s, uv_ok_s, clk_err_s} = sync_q;
  assign sd_low = ~sd_high_s;

  // ************************************************
  // registers
  // ************************************************
  amp_ctrl_pkg::amp_state_t state_q;
  amp_ctrl_pkg::amp_state_t state_d;
  logic [7:0]  clk_cfg_q;
  logic [7:0]  clk_cfg_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  volume_q;
  logic [7:0]  volume_d;
  logic [7:0]  fade_cfg_q;
  logic [7:0]  fade_cfg_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;
  logic        ack_q;
  logic        ack_d;
  logic        bus_req;
  logic        wr_take;
  logic [5:0]  reg_idx;
  logic        mute;
  logic [7:0]  gain;
  logic        gain_at_target;
  logic        limiter_q;
  logic        limiter_d;
  logic        bclk_lost;
  logic        addr_high_q;
  logic        addr_high_d;

  assign bus_req = avs_read_in | avs_write_in;
  assign reg_idx = avs_address_in[7:2];
  assign wr_take = avs_write_in & ack_q & avs_byteenable_in[0] & (state_q != amp_ctrl_pkg::ST_DOWN);
  assign mute    = ctrl_q[amp_ctrl_pkg::CTRL_MUTE_BIT];

  always_comb begin
    ack_d      = bus_req & ~ack_q;
    clk_cfg_d  = clk_cfg_q;
    ctrl_d     = ctrl_q;
    volume_d   = volume_q;
    fade_cfg_d = fade_cfg_q;
    readdata_d = readdata_q;
    if (wr_take) begin
      unique case (reg_idx)
        amp_ctrl_pkg::REG_CLK_CFG_IDX:  clk_cfg_d  = avs_writedata_in[7:0];
        amp_ctrl_pkg::REG_CTRL_IDX:     ctrl_d     = avs_writedata_in[7:0];
        amp_ctrl_pkg::REG_VOLUME_IDX:   volume_d   = avs_writedata_in[7:0];
        amp_ctrl_pkg::REG_FADE_CFG_IDX: fade_cfg_d = avs_writedata_in[7:0];
        default: ;
      endcase
    end
    if (avs_read_in && !ack_q) begin
      readdata_d = 32'h0000_0000;
      unique case (reg_idx)
        amp_ctrl_pkg::REG_CLK_CFG_IDX:  readdata_d[7:0] = clk_cfg_q;
        amp_ctrl_pkg::REG_CTRL_IDX:     readdata_d[7:0] = ctrl_q;
        amp_ctrl_pkg::REG_VOLUME_IDX:   readdata_d[7:0] = volume_q;
        amp_ctrl_pkg::REG_FADE_CFG_IDX: readdata_d[7:0] = fade_cfg_q;
        amp_ctrl_pkg::REG_STATUS_IDX: begin
          readdata_d[amp_ctrl_pkg::STAT_STATE_LSB +: 8] = state_q;
          readdata_d[amp_ctrl_pkg::STAT_GAIN_LSB +: 8]  = gain;
          readdata_d[amp_ctrl_pkg::STAT_LIMIT_BIT]      = limiter_q;
          readdata_d[amp_ctrl_pkg::STAT_BCLK_BIT]       = bclk_lost;
          readdata_d[amp_ctrl_pkg::STAT_STRAP_BIT]      = addr_high_q;
        end
        default: ;
      endcase
    end
  end

  // register file has no power-down reset, only the core reset
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q      <= 1'b0;
      clk_cfg_q  <= amp_ctrl_pkg::CLK_CFG_RST;
      ctrl_q     <= amp_ctrl_pkg::CTRL_RST;
      volume_q   <= amp_ctrl_pkg::VOLUME_RST;
      fade_cfg_q <= amp_ctrl_pkg::FADE_CFG_RST;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q      <= ack_d;
      clk_cfg_q  <= clk_cfg_d;
      ctrl_q     <= ctrl_d;
      volume_q   <= volume_d;
      fade_cfg_q <= fade_cfg_d;
      readdata_q <= readdata_d;
    end
  end

  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign avs_readdata_out    = readdata_q;
  assign pll_ratio_out       = clk_cfg_q[amp_ctrl_pkg::PLL_RATIO_MSB:amp_ctrl_pkg::PLL_RATIO_LSB];

  // ************************************************
  // bit-clock loss detector on the oscillator clock
  // ************************************************
  logic       bclk_prev_q;
  logic [7:0] idle_cnt_q;
  logic [7:0] idle_cnt_d;

  always_comb begin
    idle_cnt_d = idle_cnt_q;
    if (bclk_s != bclk_prev_q) begin
      idle_cnt_d = 8'h00;
    end else if (!bclk_lost) begin
      idle_cnt_d = idle_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bclk_prev_q <= 1'b0;
      idle_cnt_q  <= 8'h00;
    end else begin
      bclk_prev_q <= bclk_s;
      idle_cnt_q  <= idle_cnt_d;
    end
  end

  assign bclk_lost = (idle_cnt_q >= 8'(amp_ctrl_pkg::BCLK_LOSS_CYCLES));

  // ************************************************
  // fade step timer
  // ************************************************
  logic [10:0] step_cnt_q;
  logic [10:0] step_cnt_d;
  logic [2:0]  rate_cnt_q;
  logic [2:0]  rate_cnt_d;
  logic [2:0]  rate_max;
  logic        base_tick;
  logic        step_en;

  assign rate_max  = 3'((4'h1 << fade_cfg_q[amp_ctrl_pkg::FADE_RATE_MSB:amp_ctrl_pkg::FADE_RATE_LSB]) - 4'h1);
  assign base_tick = (step_cnt_q == 11'(amp_ctrl_pkg::FADE_STEP_CYCLES - 1));
  assign step_en   = base_tick & (rate_cnt_q == rate_max);

  always_comb begin
    step_cnt_d = base_tick ? 11'h000 : step_cnt_q + 11'h001;
    rate_cnt_d = rate_cnt_q;
    if (base_tick) begin
      rate_cnt_d = (rate_cnt_q == rate_max) ? 3'h0 : rate_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_cnt_q <= 11'h000;
      rate_cnt_q <= 3'h0;
    end else begin
      step_cnt_q <= step_cnt_d;
      rate_cnt_q <= rate_cnt_d;
    end
  end

  // ************************************************
  // thermal volume limiter and target gain
  // ************************************************
  logic [7:0] target;
  logic       force_zero;

  always_comb begin
    limiter_d = limiter_q;
    if (attack_s) begin
      limiter_d = 1'b1;
    end else if (release_s) begin
      limiter_d = 1'b0;
    end
  end

  always_comb begin
    target = limiter_q ? (volume_q >> amp_ctrl_pkg::DTC_SHIFT) : volume_q;
    if (mute || (state_q == amp_ctrl_pkg::ST_FADE_OUT) || (state_q == amp_ctrl_pkg::ST_DOWN)) begin
      target = 8'h00;
    end
  end

  assign force_zero = (state_q == amp_ctrl_pkg::ST_STRAP) | (state_q == amp_ctrl_pkg::ST_ERROR) |
                      (state_q == amp_ctrl_pkg::ST_UVLO) | (state_q == amp_ctrl_pkg::ST_CLKLOSS);

  amp_fade_ramp u_fade (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .step_en_in    (step_en),
    .force_zero_in (force_zero),
    .target_in     (target),
    .gain_out      (gain),
    .at_target_out (gain_at_target)
  );

  // ************************************************
  // start-up strap
  // ************************************************
  logic [7:0] strap_cnt_q;
  logic [7:0] strap_cnt_d;
  logic       strap_done;

  assign strap_done = (strap_cnt_q == 8'(amp_ctrl_pkg::STRAP_CYCLES));

  always_comb begin
    strap_cnt_d = strap_cnt_q;
    addr_high_d = addr_high_q;
    if (!strap_done) begin
      strap_cnt_d = strap_cnt_q + 8'h01;
      addr_high_d = strap_s;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_cnt_q <= 8'h00;
      addr_high_q <= 1'b0;
      limiter_q   <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      addr_high_q <= addr_high_d;
      limiter_q   <= limiter_d;
    end
  end

  assign bus_address_out = addr_high_q ? amp_ctrl_pkg::BUS_ADDR_HIGH : amp_ctrl_pkg::BUS_ADDR_LOW;

  // ************************************************
  // sequencer
  // ************************************************
  logic prot_event;
  logic clk_bad;
  logic err_exit;

  assign prot_event = hot_s | short_s;
  assign clk_bad    = clk_err_s | bclk_lost;
  assign err_exit   = ~short_s & cool_s & (sd_low | mute);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      amp_ctrl_pkg::ST_STRAP: begin
        if (strap_done) begin
          state_d = amp_ctrl_pkg::ST_FADE_IN;
        end
      end
      amp_ctrl_pkg::ST_ERROR: begin
        if (err_exit) begin
          state_d = amp_ctrl_pkg::ST_FADE_IN;
        end
      end
      amp_ctrl_pkg::ST_UVLO: begin
        if (uv_ok_s && !uv_low_s) begin
          state_d = amp_ctrl_pkg::ST_FADE_IN;
        end
      end
      amp_ctrl_pkg::ST_CLKLOSS: begin
        if (!clk_bad) begin
          state_d = amp_ctrl_pkg::ST_FADE_IN;
        end
      end
      amp_ctrl_pkg::ST_DOWN: begin
        if (!sd_low) begin
          state_d = amp_ctrl_pkg::ST_FADE_IN;
        end
      end
      amp_ctrl_pkg::ST_FADE_OUT: begin
        if (!sd_low) begin
          state_d = amp_ctrl_pkg::ST_FADE_IN;
        end else if (gain == 8'h00) begin
          state_d = amp_ctrl_pkg::ST_DOWN;
        end
      end
      amp_ctrl_pkg::ST_FADE_IN: begin
        if (sd_low) begin
          state_d = amp_ctrl_pkg::ST_FADE_OUT;
        end else if (gain_at_target) begin
          state_d = amp_ctrl_pkg::ST_RUN;
        end
      end
      amp_ctrl_pkg::ST_RUN: begin
        if (sd_low) begin
          state_d = amp_ctrl_pkg::ST_FADE_OUT;
        end
      end
      default: state_d = amp_ctrl_pkg::ST_STRAP;
    endcase
    if (state_q != amp_ctrl_pkg::ST_STRAP) begin
      if (uv_low_s) begin
        state_d = amp_ctrl_pkg::ST_UVLO;
      end else if (prot_event) begin
        state_d = amp_ctrl_pkg::ST_ERROR;
      end else if (clk_bad && (state_q != amp_ctrl_pkg::ST_ERROR) && (state_q != amp_ctrl_pkg::ST_UVLO)
                   && (state_q != amp_ctrl_pkg::ST_DOWN)) begin
        state_d = amp_ctrl_pkg::ST_CLKLOSS;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= amp_ctrl_pkg::ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************
  // power, clock and pin controls
  // ************************************************
  logic in_audio;

  assign in_audio = (state_q == amp_ctrl_pkg::ST_RUN) | (state_q == amp_ctrl_pkg::ST_FADE_OUT) |
                    (state_q == amp_ctrl_pkg::ST_FADE_IN);

  assign gain_out            = gain;
  assign power_stage_en_out  = in_audio;
  assign digital_clk_en_out  = (state_q != amp_ctrl_pkg::ST_DOWN) & (state_q != amp_ctrl_pkg::ST_UVLO);
  assign analog_bias_en_out  = (state_q != amp_ctrl_pkg::ST_DOWN);
  assign pll_ref_osc_sel_out = (state_q == amp_ctrl_pkg::ST_CLKLOSS) | (state_q == amp_ctrl_pkg::ST_STRAP) |
                               output_weak_low_out;
  assign output_weak_low_out = bclk_lost & (state_q != amp_ctrl_pkg::ST_STRAP);
  assign pop_suppress_out    = (state_q != amp_ctrl_pkg::ST_RUN) | ~gain_at_target;
  assign fault_pin_out       = 1'b0;
  assign fault_pin_oe_b_out  = ~((state_q == amp_ctrl_pkg::ST_ERROR) | output_weak_low_out);

endmodule : amp_shutdown_fault_control

// ### dv/amp_sfc_assertions.sv
// port checks for the amplifier shutdown and fault sequencer
`timescale 1ns/1ps
module amp_sfc_checker (
  input wire logic       core_clk_in,
  input wire logic       rst_b_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [7:0] gain_out,
  input wire logic       power_stage_en_out,
  input wire logic       digital_clk_en_out,
  input wire logic       analog_bias_en_out,
  input wire logic       pll_ref_osc_sel_out,
  input wire logic       output_weak_low_out,
  input wire logic       pop_suppress_out,
  input wire logic       fault_pin_oe_b_out,
  input wire logic [6:0] bus_address_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_wt; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_wt: assert property (p_wt) else $error("bus wait longer than one cycle");
  property p_down; !analog_bias_en_out |-> !power_stage_en_out && !digital_clk_en_out && gain_out == 8'h00; endproperty
  a_down: assert property (p_down) else $error("power-down not complete");
  property p_up; power_stage_en_out |-> digital_clk_en_out && analog_bias_en_out; endproperty
  a_up: assert property (p_up) else $error("stages on without bias or clocks");
  property p_step;
    power_stage_en_out && $past(power_stage_en_out) && !pll_ref_osc_sel_out
      |-> 8'(gain_out - $past(gain_out)) inside {8'h00, 8'h01, 8'hff};
  endproperty
  a_step: assert property (p_step) else $error("gain jumped");
  property p_loss; output_weak_low_out |-> !fault_pin_oe_b_out && pll_ref_osc_sel_out; endproperty
  a_loss: assert property (p_loss) else $error("clock loss outputs wrong");
  property p_err; !fault_pin_oe_b_out && !output_weak_low_out |-> !power_stage_en_out; endproperty
  a_err: assert property (p_err) else $error("stages on during fault");
  property p_addr; !pop_suppress_out |-> $stable(bus_address_out) && bus_address_out inside {7'h30, 7'h34}; endproperty
  a_addr: assert property (p_addr) else $error("bus address wrong");
  property p_pop; gain_out != $past(gain_out) |-> $past(pop_suppress_out); endproperty
  a_pop: assert property (p_pop) else $error("gain change without pop suppression");
endmodule : amp_sfc_checker
bind amp_shutdown_fault_control amp_sfc_checker amp_sfc_checker_i (.*);

// ### dv/amp_host_model.sv
// control-bus host model: one Avalon access per request, released lines inverted
`timescale 1ns/1ps
module amp_host_model (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [7:0]  a_in,
  input  wire logic [31:0] d_in,
  input  wire logic        wt_in,
  input  wire logic [31:0] q_in,
  output logic             rd_out,
  output logic             wr_out,
  output logic [7:0]       a_out,
  output logic [31:0]      d_out,
  output logic             done_out,
  output logic [31:0]      q_out
);
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {rd_out, wr_out, done_out, a_out, d_out} <= '0;
    end else if ((rd_out || wr_out) && !wt_in) begin
      {rd_out, wr_out, done_out, q_out} <= {3'h1, q_in};
      a_out <= ~a_out;
      d_out <= ~d_out;
    end else begin
      done_out <= 1'b0;
      if (req_in && !done_out && !rd_out && !wr_out) {rd_out, wr_out, a_out, d_out} <= {!wr_in, wr_in, a_in, d_in};
    end
  end
endmodule : amp_host_model

// ### dv/amp_shutdown_fault_control_tb.sv
// self-checking bench for the amplifier shutdown and fault sequencer
`timescale 1ns/1ps
module amp_shutdown_fault_control_tb;
  logic core_clk_in = 1'b0, rst_b_in = 1'b0, bclk_in = 1'b0, run = 1'b1, req = 1'b0, wr = 1'b0, done;
  logic avs_read_in, avs_write_in, avs_waitrequest_out, fault_pin_in, fault_pin_out, fault_pin_oe_b_out;
  logic shutdown_request_pin_b_in = 1'b1, thermal_attack_in = 1'b0, thermal_release_in = 1'b0;
  logic over_temp_160_in = 1'b0, temp_below_125_in = 1'b1, short_circuit_in = 1'b0, clock_error_in = 1'b0;
  logic core_supply_low_in = 1'b0, core_supply_ok_in = 1'b1, power_stage_en_out, digital_clk_en_out;
  logic analog_bias_en_out, pll_ref_osc_sel_out, output_weak_low_out, pop_suppress_out;
  logic [3:0] avs_byteenable_in = 4'hf, pll_ratio_out;
  logic [6:0] bus_address_out;
  logic [7:0] avs_address_in, gain_out, addr, vol;
  logic [31:0] avs_writedata_in, avs_readdata_out, wd, rd, r, seed = 32'hfab1_bd3c;
  logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h0c, 8'h58, 8'hfc};
  logic [7:0] rv [5] = '{8'h91, 8'h00, 8'hc0, 8'h00, 8'h00};
  int n_fail = 0, checks_done = 0, i, n;
  always #2 core_clk_in = ~core_clk_in;
  always #62.5 if (run) bclk_in = ~bclk_in;
  amp_host_model amp_host_model_i (.core_clk_in, .rst_b_in, .req_in(req), .wr_in(wr), .a_in(addr), .d_in(wd),
    .wt_in(avs_waitrequest_out), .q_in(avs_readdata_out), .rd_out(avs_read_in), .wr_out(avs_write_in),
    .a_out(avs_address_in), .d_out(avs_writedata_in), .done_out(done), .q_out(rd));
  amp_shutdown_fault_control amp_shutdown_fault_control_i (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // 128 frames at 96 kHz in ns, over 256 gain steps of 4 ns cycles
  function automatic logic [31:0] exp_step(input logic rt);
    return (32'h0014_5855 / 32'h0000_0400) << rt;
  endfunction : exp_step
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang();
    chk(32'h0000_0000, 32'h0000_0001);
    close_out();
  endtask : hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wd <= d;
    for (n = 0; n < 9 && done !== 1'b1; n++) @(posedge core_clk_in);
    req <= 1'b0;
    if (n == 9) hang();
    @(posedge core_clk_in);
  endtask : bus
  task automatic wait_st(input logic [7:0] st);
    int j;
    for (j = 0; j < 9000; j++) begin
      bus(1'b0, 8'h80, 32'h0000_0000);
      if (rd[7:0] === st) return;
    end
    hang();
  endtask : wait_st
  task automatic wait_g(input logic [7:0] g);
    int j;
    for (j = 0; j < 30000 && gain_out !== g; j++) @(posedge core_clk_in);
    if (gain_out !== g) hang();
  endtask : wait_g
  initial begin
    r = rnd();
    fault_pin_in <= r[0];
    vol = 8'h02 + {7'h00, r[1]};
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    @(posedge core_clk_in);
    bus(1'b1, 8'hfc, rnd());
    for (i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000);
      chk(rd, 32'(rv[i]));
    end
    chk(32'(pll_ratio_out), 32'h0000_0001);
    bus(1'b1, 8'h04, 32'({4'h9, r[5:2]}));
    chk(32'(pll_ratio_out), 32'(r[5:2]));
    bus(1'b1, 8'h0c, 32'(vol));
    wait_st(8'h02);
    chk(32'({bus_address_out, gain_out}), 32'({(r[0] ? 7'h34 : 7'h30), vol}));
    shutdown_request_pin_b_in <= 1'b0;
    wait_st(8'h08);
    chk(32'({gain_out, power_stage_en_out, digital_clk_en_out, analog_bias_en_out}), 32'h0000_0000);
    bus(1'b1, 8'h0c, 32'h0000_0001);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'(vol));
    shutdown_request_pin_b_in <= 1'b1;
    wait_g(vol);
    shutdown_request_pin_b_in <= 1'b0;
    wait_g(vol - 8'h01);
    chk(32'(pop_suppress_out), 32'h0000_0001);
    shutdown_request_pin_b_in <= 1'b1;
    wait_st(8'h02);
    chk(32'({gain_out, digital_clk_en_out}), 32'({vol, 1'b1}));
    thermal_attack_in <= 1'b1;
    wait_g(vol >> 1);
    thermal_attack_in <= 1'b0;
    thermal_release_in <= 1'b1;
    wait_g(vol);
    thermal_release_in <= 1'b0;
    bus(1'b1, 8'h58, 32'({r[7], 2'h0}));
    vol = vol + 8'h02;
    bus(1'b1, 8'h0c, 32'(vol));
    wait_g(vol - 8'h01);
    for (n = 0; n < 12000 && gain_out !== vol; n++) @(posedge core_clk_in);
    chk(32'(n), exp_step(r[7]));
    bus(1'b1, 8'h58, 32'h0000_0000);
    run = 1'b0;
    repeat (100) @(posedge core_clk_in);
    chk(32'(output_weak_low_out), 32'h0000_0000);
    repeat (60) @(posedge core_clk_in);
    chk(32'({output_weak_low_out, fault_pin_oe_b_out, pll_ref_osc_sel_out}), 32'h0000_0005);
    run = 1'b1;
    repeat (40) @(posedge core_clk_in);
    chk(32'({output_weak_low_out, fault_pin_oe_b_out}), 32'h0000_0001);
    wait_g(vol);
    clock_error_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    chk(32'({pll_ref_osc_sel_out, gain_out}), 32'h0000_0100);
    clock_error_in <= 1'b0;
    wait_g(vol);
    for (i = 0; i < 2; i++) begin
      short_circuit_in <= (i == 0);
      over_temp_160_in <= (i == 1);
      temp_below_125_in <= (i == 0);
      repeat (8) @(posedge core_clk_in);
      chk(32'({fault_pin_out, fault_pin_oe_b_out, power_stage_en_out}), 32'h0000_0000);
      short_circuit_in <= 1'b0;
      over_temp_160_in <= 1'b0;
      temp_below_125_in <= 1'b1;
      repeat (20) @(posedge core_clk_in);
      chk(32'(fault_pin_oe_b_out), 32'h0000_0000);
      bus(1'b1, 8'h08, 32'h0000_0008);
      wait_st(8'h02);
      bus(1'b1, 8'h08, 32'h0000_0000);
      wait_g(vol);
    end
    shutdown_request_pin_b_in <= 1'b0;
    wait_st(8'h08);
    core_supply_low_in <= 1'b1;
    core_supply_ok_in <= 1'b0;
    wait_st(8'h40);
    chk(32'(power_stage_en_out), 32'h0000_0000);
    shutdown_request_pin_b_in <= 1'b1;
    core_supply_low_in <= 1'b0;
    core_supply_ok_in <= 1'b1;
    wait_st(8'h02);
    close_out();
  end
endmodule : amp_shutdown_fault_control_tb
